// *** logic/ivp_pkg.sv ***
package ivp_pkg;

  // Control register at its I/O address
  localparam logic [5:0] MCU_CONTROL_ADDR  = 6'h35;
  localparam logic [7:0] MCU_CONTROL_RESET = 8'h00;
  localparam int         UNLOCK_BIT        = 0;
  localparam int         SELECT_BIT        = 1;
  localparam int         PULLUP_BIT        = 4;

  // Cycles for which the change unlock stays open
  localparam logic [2:0] UNLOCK_CYCLES = 3'h4;

  // Boot section start word address for each boot-size code
  localparam logic [13:0] BOOT_START_2K   = 14'h3C00;
  localparam logic [13:0] BOOT_START_1K   = 14'h3E00;
  localparam logic [13:0] BOOT_START_512  = 14'h3F00;
  localparam logic [13:0] BOOT_START_256  = 14'h3F80;
  localparam logic [13:0] FLASH_START     = 14'h0000;

  // Vector numbers
  localparam logic [4:0] VEC_RESET = 5'h01;
  localparam logic [4:0] VEC_LAST  = 5'h1A;

  // Vector table word offsets, two words per entry
  localparam logic [13:0] OFS_RESET        = 14'h0000;
  localparam logic [13:0] OFS_EXT_ZERO     = 14'h0002;
  localparam logic [13:0] OFS_EXT_ONE      = 14'h0004;
  localparam logic [13:0] OFS_PCHG_ZERO    = 14'h0006;
  localparam logic [13:0] OFS_PCHG_ONE     = 14'h0008;
  localparam logic [13:0] OFS_PCHG_TWO     = 14'h000A;
  localparam logic [13:0] OFS_WATCHDOG     = 14'h000C;
  localparam logic [13:0] OFS_T2_CMP_A     = 14'h000E;
  localparam logic [13:0] OFS_T2_CMP_B     = 14'h0010;
  localparam logic [13:0] OFS_T2_OVF       = 14'h0012;
  localparam logic [13:0] OFS_T1_CAPT      = 14'h0014;
  localparam logic [13:0] OFS_T1_CMP_A     = 14'h0016;
  localparam logic [13:0] OFS_T1_CMP_B     = 14'h0018;
  localparam logic [13:0] OFS_T1_OVF       = 14'h001A;
  localparam logic [13:0] OFS_T0_CMP_A     = 14'h001C;
  localparam logic [13:0] OFS_T0_CMP_B     = 14'h001E;
  localparam logic [13:0] OFS_T0_OVF       = 14'h0020;
  localparam logic [13:0] OFS_SER_XFER     = 14'h0022;
  localparam logic [13:0] OFS_RX_DONE      = 14'h0024;
  localparam logic [13:0] OFS_TX_EMPTY     = 14'h0026;
  localparam logic [13:0] OFS_TX_DONE      = 14'h0028;
  localparam logic [13:0] OFS_CONV_DONE    = 14'h002A;
  localparam logic [13:0] OFS_EEPROM_READY = 14'h002C;
  localparam logic [13:0] OFS_ANALOG_CMP   = 14'h002E;
  localparam logic [13:0] OFS_TWO_WIRE     = 14'h0030;
  localparam logic [13:0] OFS_STORE_READY  = 14'h0032;

  typedef enum logic [1:0] {
    UNLOCK_IDLE,
    UNLOCK_ARMED,
    UNLOCK_HOLD
  } ivp_unlock_t;

  function automatic logic [13:0] boot_start(input logic [1:0] sizeFuses);
    case (sizeFuses)
      2'h0:    boot_start = BOOT_START_2K;
      2'h1:    boot_start = BOOT_START_1K;
      2'h2:    boot_start = BOOT_START_512;
      default: boot_start = BOOT_START_256;
    endcase
  endfunction

  function automatic logic [13:0] vector_base(input logic       sel,
                                              input logic [1:0] sizeFuses);
    vector_base = sel ? boot_start(sizeFuses) : FLASH_START;
  endfunction

  // Fuse value one means unprogrammed
  function automatic logic [13:0] reset_base(input logic       fuse,
                                             input logic [1:0] sizeFuses);
    reset_base = fuse ? FLASH_START : boot_start(sizeFuses);
  endfunction

endpackage

// *** logic/ivp_vector_rom.sv ***
`timescale 1ns/1ns
module ivp_vector_rom (
  // Clock and control
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // Lookup
  input  wire logic        rdEn,
  input  wire logic [4:0]  vecNum,
  output logic      [13:0] offset_q
);

  logic [13:0] offset_d;

  always_comb
  begin
    offset_d = offset_q;
    if (rdEn)
    begin
      case (vecNum)
        5'h01:   offset_d = ivp_pkg::OFS_RESET;
        5'h02:   offset_d = ivp_pkg::OFS_EXT_ZERO;
        5'h03:   offset_d = ivp_pkg::OFS_EXT_ONE;
        5'h04:   offset_d = ivp_pkg::OFS_PCHG_ZERO;
        5'h05:   offset_d = ivp_pkg::OFS_PCHG_ONE;
        5'h06:   offset_d = ivp_pkg::OFS_PCHG_TWO;
        5'h07:   offset_d = ivp_pkg::OFS_WATCHDOG;
        5'h08:   offset_d = ivp_pkg::OFS_T2_CMP_A;
        5'h09:   offset_d = ivp_pkg::OFS_T2_CMP_B;
        5'h0A:   offset_d = ivp_pkg::OFS_T2_OVF;
        5'h0B:   offset_d = ivp_pkg::OFS_T1_CAPT;
        5'h0C:   offset_d = ivp_pkg::OFS_T1_CMP_A;
        5'h0D:   offset_d = ivp_pkg::OFS_T1_CMP_B;
        5'h0E:   offset_d = ivp_pkg::OFS_T1_OVF;
        5'h0F:   offset_d = ivp_pkg::OFS_T0_CMP_A;
        5'h10:   offset_d = ivp_pkg::OFS_T0_CMP_B;
        5'h11:   offset_d = ivp_pkg::OFS_T0_OVF;
        5'h12:   offset_d = ivp_pkg::OFS_SER_XFER;
        5'h13:   offset_d = ivp_pkg::OFS_RX_DONE;
        5'h14:   offset_d = ivp_pkg::OFS_TX_EMPTY;
        5'h15:   offset_d = ivp_pkg::OFS_TX_DONE;
        5'h16:   offset_d = ivp_pkg::OFS_CONV_DONE;
        5'h17:   offset_d = ivp_pkg::OFS_EEPROM_READY;
        5'h18:   offset_d = ivp_pkg::OFS_ANALOG_CMP;
        5'h19:   offset_d = ivp_pkg::OFS_TWO_WIRE;
        5'h1A:   offset_d = ivp_pkg::OFS_STORE_READY;
        // Unused numbers fall back on the reset entry
        default: offset_d = ivp_pkg::OFS_RESET;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
      offset_q <= ivp_pkg::OFS_RESET;
    else if (ce)
      offset_q <= offset_d;
  end

endmodule

// *** logic/ivp_top.sv ***
`timescale 1ns/1ns
module ivp_top (
  // Clock, reset, enable
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        ce,
  // I/O register port
  input  wire logic [5:0]  ioAddr,
  input  wire logic        ioWe,
  input  wire logic        ioRe,
  input  wire logic [7:0]  ioWdata,
  output logic      [7:0]  ioRdata_q,
  // Fuses and lock bits, zero means programmed
  input  wire logic        bootResetFuse,
  input  wire logic [1:0]  bootSizeFuses,
  input  wire logic        appSectionLockBit,
  input  wire logic        loaderSectionLockBit,
  // Core fetch and interrupt entry
  input  wire logic [13:0] fetchAddr,
  input  wire logic        instrRetire,
  input  wire logic        vecReq,
  input  wire logic [4:0]  vecNum,
  output logic             vecAck_q,
  output logic      [13:0] vecAddr_q,
  output logic      [13:0] resetAddr_q,
  output logic             irqBlock_q,
  // Control bits as seen by the rest of the chip
  output logic             vectorBaseSelect_q,
  output logic             vectorChangeUnlock_q,
  output logic             pullupGlobalOff_q
);

  // Decode and live addresses
  logic        mcuWrite;
  logic        mcuRead;
  logic [13:0] bootStart;
  logic [13:0] resetBase;
  logic [13:0] vecBase;
  logic        lockHit;

  assign mcuWrite  = ioWe && (ioAddr == ivp_pkg::MCU_CONTROL_ADDR);
  assign mcuRead   = ioRe && (ioAddr == ivp_pkg::MCU_CONTROL_ADDR);
  assign bootStart = ivp_pkg::boot_start(bootSizeFuses);
  assign resetBase = ivp_pkg::reset_base(bootResetFuse,
                                         bootSizeFuses);
  assign vecBase   = ivp_pkg::vector_base(vectorBaseSelect_q,
                                          bootSizeFuses);

  // Lock bits only matter for the area that does not hold the vectors
  always_comb
  begin
    if (vectorBaseSelect_q)
      lockHit = !appSectionLockBit && (fetchAddr < bootStart);
    else
      lockHit = !loaderSectionLockBit && (fetchAddr >= bootStart);
  end

  // Unlock sequencer
  ivp_pkg::ivp_unlock_t state_q;
  ivp_pkg::ivp_unlock_t state_d;
  logic [2:0]           count_q;
  logic [2:0]           count_d;
  logic                 select_d;
  logic                 pullup_d;

  always_comb
  begin
    state_d  = state_q;
    count_d  = count_q;
    select_d = vectorBaseSelect_q;
    pullup_d = pullupGlobalOff_q;
    if (mcuWrite)
      pullup_d = ioWdata[ivp_pkg::PULLUP_BIT];
    case (state_q)
      ivp_pkg::UNLOCK_IDLE:
      begin
        if (mcuWrite && ioWdata[ivp_pkg::UNLOCK_BIT])
        begin
          state_d = ivp_pkg::UNLOCK_ARMED;
          count_d = ivp_pkg::UNLOCK_CYCLES;
        end
      end
      ivp_pkg::UNLOCK_ARMED:
      begin
        if (mcuWrite && !ioWdata[ivp_pkg::UNLOCK_BIT])
        begin
          // Select taken, unlock closes at once, mask held a little longer
          select_d = ioWdata[ivp_pkg::SELECT_BIT];
          state_d  = ivp_pkg::UNLOCK_HOLD;
          count_d  = 3'h0;
        end
        else if (mcuWrite)
          count_d = ivp_pkg::UNLOCK_CYCLES; // Re-arming restarts the window
        else if (count_q == 3'h1)
        begin
          state_d = ivp_pkg::UNLOCK_IDLE;
          count_d = 3'h0;
        end
        else
          count_d = count_q - 3'h1;
      end
      ivp_pkg::UNLOCK_HOLD:
      begin
        if (mcuWrite && ioWdata[ivp_pkg::UNLOCK_BIT])
        begin
          state_d = ivp_pkg::UNLOCK_ARMED;
          count_d = ivp_pkg::UNLOCK_CYCLES;
        end
        else if (instrRetire)
          state_d = ivp_pkg::UNLOCK_IDLE;
      end
      default:
      begin
        state_d = ivp_pkg::UNLOCK_IDLE;
        count_d = 3'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      state_q            <= ivp_pkg::UNLOCK_IDLE;
      count_q            <= 3'h0;
      vectorBaseSelect_q <= ivp_pkg::MCU_CONTROL_RESET[ivp_pkg::SELECT_BIT];
      pullupGlobalOff_q  <= ivp_pkg::MCU_CONTROL_RESET[ivp_pkg::PULLUP_BIT];
    end
    else if (ce)
    begin
      state_q            <= state_d;
      count_q            <= count_d;
      vectorBaseSelect_q <= select_d;
      pullupGlobalOff_q  <= pullup_d;
    end
  end

  // Status outputs and read data
  logic        unlock_d;
  logic        irqBlock_d;
  logic [13:0] resetAddr_d;
  logic [7:0]  ioRdata_d;

  always_comb
  begin
    unlock_d    = (state_d == ivp_pkg::UNLOCK_ARMED);
    // Only the core's acceptance is gated; its global enable flag is never
    // written from here, so software sees it unchanged after the sequence
    irqBlock_d  = (state_d != ivp_pkg::UNLOCK_IDLE) || lockHit;
    resetAddr_d = resetBase + ivp_pkg::OFS_RESET;
    ioRdata_d   = ioRdata_q;
    if (mcuRead)
    begin
      ioRdata_d                       = 8'h00;
      ioRdata_d[ivp_pkg::UNLOCK_BIT]  = vectorChangeUnlock_q;
      ioRdata_d[ivp_pkg::SELECT_BIT]  = vectorBaseSelect_q;
      ioRdata_d[ivp_pkg::PULLUP_BIT]  = pullupGlobalOff_q;
    end
    else if (ioRe)
      ioRdata_d = 8'h00;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      vectorChangeUnlock_q <= ivp_pkg::MCU_CONTROL_RESET[ivp_pkg::UNLOCK_BIT];
      irqBlock_q           <= 1'b0;
      resetAddr_q          <= ivp_pkg::FLASH_START;
      ioRdata_q            <= ivp_pkg::MCU_CONTROL_RESET;
    end
    else if (ce)
    begin
      vectorChangeUnlock_q <= unlock_d;
      irqBlock_q           <= irqBlock_d;
      resetAddr_q          <= resetAddr_d;
      ioRdata_q            <= ioRdata_d;
    end
  end

  // Vector lookup pipeline: table read, then base add
  logic [13:0] tableOffset;
  logic        s1Valid_q;
  logic        s1Valid_d;
  logic [13:0] s1Base_q;
  logic [13:0] s1Base_d;
  logic        vecAck_d;
  logic [13:0] vecAddr_d;

  ivp_vector_rom u_rom (
    .ref_clk  (ref_clk),
    .srst     (srst),
    .ce       (ce),
    .rdEn     (vecReq),
    .vecNum   (vecNum),
    .offset_q (tableOffset)
  );

  always_comb
  begin
    s1Valid_d = vecReq;
    s1Base_d  = s1Base_q;
    if (vecReq)
      s1Base_d = (vecNum == ivp_pkg::VEC_RESET) ? resetBase : vecBase;
    vecAck_d  = s1Valid_q;
    vecAddr_d = vecAddr_q;
    if (s1Valid_q)
      vecAddr_d = s1Base_q + tableOffset;
  end

  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      s1Valid_q <= 1'b0;
      s1Base_q  <= ivp_pkg::FLASH_START;
      vecAck_q  <= 1'b0;
      vecAddr_q <= ivp_pkg::FLASH_START;
    end
    else if (ce)
    begin
      s1Valid_q <= s1Valid_d;
      s1Base_q  <= s1Base_d;
      vecAck_q  <= vecAck_d;
      vecAddr_q <= vecAddr_d;
    end
  end

  // Checking helpers
  logic [13:0] expAddr;
  logic        numInRange;

  assign numInRange = (vecNum >= ivp_pkg::VEC_RESET) &&
                      (vecNum <= ivp_pkg::VEC_LAST);
  assign expAddr    = ((vecNum == ivp_pkg::VEC_RESET) ? resetBase : vecBase)
                      + {8'h00, vecNum - 5'h01, 1'b0};

  a_unlock_arms: assert property (
    @(posedge ref_clk) disable iff (srst)
    (ce && mcuWrite && ioWdata[0] && state_q == ivp_pkg::UNLOCK_IDLE)
    |=> vectorChangeUnlock_q && irqBlock_q
  ) else $error("unlock did not arm with mask");

  a_unlock_expires: assert property (
    @(posedge ref_clk) disable iff (srst)
    (ce && mcuWrite && ioWdata[0] && state_q == ivp_pkg::UNLOCK_IDLE)
    ##1 (ce && !ioWe && !lockHit)[*4]
    |=> !vectorChangeUnlock_q && !irqBlock_q
  ) else $error("unlock or mask not released after four cycles");

  a_unlock_window: assert property (
    @(posedge ref_clk) disable iff (srst)
    (ce && mcuWrite && ioWdata[0] && state_q == ivp_pkg::UNLOCK_IDLE)
    ##1 (ce && !ioWe)[*3]
    |=> vectorChangeUnlock_q
  ) else $error("unlock closed before four cycles");

  a_select_locked: assert property (
    @(posedge ref_clk) disable iff (srst)
    (ce && mcuWrite && !vectorChangeUnlock_q) |=> $stable(vectorBaseSelect_q)
  ) else $error("select changed without unlock");

  a_select_taken: assert property (
    @(posedge ref_clk) disable iff (srst)
    (ce && mcuWrite && vectorChangeUnlock_q && !ioWdata[0])
    |=> (vectorBaseSelect_q == $past(ioWdata[1])) && !vectorChangeUnlock_q
        && irqBlock_q
  ) else $error("select write not taken or unlock left open");

  a_hold_release: assert property (
    @(posedge ref_clk) disable iff (srst)
    (ce && state_q == ivp_pkg::UNLOCK_HOLD && instrRetire && !ioWe
     && !lockHit) |=> !irqBlock_q
  ) else $error("mask held after following instruction");

  a_lock_blocks: assert property (
    @(posedge ref_clk) disable iff (srst)
    (ce && lockHit) |=> irqBlock_q
  ) else $error("lock bit did not block interrupts");

  a_reset_addr: assert property (
    @(posedge ref_clk) disable iff (srst)
    ce |=> resetAddr_q == ($past(bootResetFuse) ? 14'h0000
                           : ivp_pkg::boot_start($past(bootSizeFuses)))
  ) else $error("reset address wrong for fuse setting");

  a_vector_addr: assert property (
    @(posedge ref_clk) disable iff (srst)
    (ce && vecReq && numInRange) ##1 ce
    |=> vecAck_q && (vecAddr_q == $past(expAddr, 2))
  ) else $error("vector address wrong");

  a_reg_read: assert property (
    @(posedge ref_clk) disable iff (srst)
    (ce && mcuRead) |=> ioRdata_q == {3'h0, $past(pullupGlobalOff_q), 2'h0,
                                      $past(vectorBaseSelect_q),
                                      $past(vectorChangeUnlock_q)}
  ) else $error("control register read data wrong");

endmodule

// *** tb/ivp_core_model.sv ***
`timescale 1ns/1ns
module ivp_core_model (
  // Clock
  input  wire logic        ref_clk,
  // Vector answer
  input  wire logic        vecAck_q,
  input  wire logic [13:0] vecAddr_q,
  // Core requests
  output logic             vecReq,
  output logic      [4:0]  vecNum,
  output logic      [13:0] fetchAddr,
  output logic             instrRetire
);
  initial
  begin
    vecReq      = 1'b0;
    vecNum      = 5'h1F;
    fetchAddr   = 14'h0000;
    instrRetire = 1'b0;
  end

  // Number is scrambled after release so a late sample cannot pass
  task automatic fetch(input logic [4:0] n, output logic [13:0] a);
    int waitCnt;
    @(negedge ref_clk);
    vecReq = 1'b1;
    vecNum = n;
    @(negedge ref_clk);
    vecReq = 1'b0;
    vecNum = ~n;
    waitCnt = 0;
    while (vecAck_q !== 1'b1 && waitCnt < 4)
    begin
      @(negedge ref_clk);
      waitCnt++;
    end
    a = (vecAck_q === 1'b1) ? vecAddr_q : 14'hxxxx;
  endtask

  task automatic retire;
    @(negedge ref_clk);
    instrRetire = 1'b1;
    @(negedge ref_clk);
    instrRetire = 1'b0;
  endtask

  task automatic set_pc(input logic [13:0] a);
    @(negedge ref_clk);
    fetchAddr = a;
  endtask
endmodule

// *** tb/ivp_top_tb.sv ***
`timescale 1ns/1ns
module ivp_top_tb;
  logic        ref_clk;
  logic        srst;
  logic        ce;
  logic [5:0]  ioAddr;
  logic        ioWe;
  logic        ioRe;
  logic [7:0]  ioWdata;
  logic [7:0]  ioRdata_q;
  logic        bootResetFuse;
  logic [1:0]  bootSizeFuses;
  logic        appSectionLockBit;
  logic        loaderSectionLockBit;
  logic [13:0] fetchAddr;
  logic        instrRetire;
  logic        vecReq;
  logic [4:0]  vecNum;
  logic        vecAck_q;
  logic [13:0] vecAddr_q;
  logic [13:0] resetAddr_q;
  logic        irqBlock_q;
  logic        vectorBaseSelect_q;
  logic        vectorChangeUnlock_q;
  logic        pullupGlobalOff_q;
  logic [13:0] got;
  logic [13:0] bootStart [4];
  logic [5:0]  ctl;
  int          miscompares;
  int          n_compared;

  ivp_top dut (
    .ref_clk(ref_clk), .srst(srst), .ce(ce),
    .ioAddr(ioAddr), .ioWe(ioWe), .ioRe(ioRe), .ioWdata(ioWdata),
    .ioRdata_q(ioRdata_q), .bootResetFuse(bootResetFuse),
    .bootSizeFuses(bootSizeFuses), .appSectionLockBit(appSectionLockBit),
    .loaderSectionLockBit(loaderSectionLockBit), .fetchAddr(fetchAddr),
    .instrRetire(instrRetire), .vecReq(vecReq), .vecNum(vecNum),
    .vecAck_q(vecAck_q), .vecAddr_q(vecAddr_q), .resetAddr_q(resetAddr_q),
    .irqBlock_q(irqBlock_q), .vectorBaseSelect_q(vectorBaseSelect_q),
    .vectorChangeUnlock_q(vectorChangeUnlock_q),
    .pullupGlobalOff_q(pullupGlobalOff_q)
  );

  ivp_core_model core (
    .ref_clk(ref_clk), .vecAck_q(vecAck_q), .vecAddr_q(vecAddr_q),
    .vecReq(vecReq), .vecNum(vecNum), .fetchAddr(fetchAddr),
    .instrRetire(instrRetire)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic chk(input string what, input logic [13:0] exp,
                     input logic [13:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    ioAddr  = a;
    ioWdata = d;
    ioWe    = 1'b1;
    @(negedge ref_clk);
    ioWe    = 1'b0;
    ioWdata = ~d;
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    ioAddr = a;
    ioRe   = 1'b1;
    @(negedge ref_clk);
    ioRe   = 1'b0;
    chk("ioRdata_q", {6'h00, exp}, {6'h00, ioRdata_q});
  endtask

  task automatic blk(input logic exp);
    repeat (2) @(negedge ref_clk);
    chk("irqBlock_q", 14'(exp), {13'h0000, irqBlock_q});
  endtask

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge ref_clk);
    miscompares++;
    $display("watchdog expired");
    close_out();
  end

  initial
  begin
    ctl = ivp_pkg::MCU_CONTROL_ADDR;
    miscompares = 0;
    n_compared = 0;
    srst = 1'b1;
    ce = 1'b1;
    ioAddr = ctl;
    ioWe = 1'b0;
    ioRe = 1'b0;
    ioWdata = 8'h00;
    bootResetFuse = 1'b1;
    bootSizeFuses = 2'h0;
    appSectionLockBit = 1'b1;
    loaderSectionLockBit = 1'b1;
    bootStart = '{14'h3C00, 14'h3E00, 14'h3F00, 14'h3F80};
    repeat (20) @(negedge ref_clk);
    srst = 1'b0;
    rd(ctl, 8'h00);
    rd(6'h3F, 8'h00);
    chk("resetAddr_q", 14'h0000, resetAddr_q);
    $display("test reset_state done");
    for (int n = 1; n <= 26; n++)
    begin
      core.fetch(n[4:0], got);
      chk("vecAddr_q", 14'(2 * (n - 1)), got);
    end
    // The answer strobe must have dropped again one cycle later
    @(negedge ref_clk);
    chk("vecAck_q", 14'h0000, {13'h0000, vecAck_q});
    $display("test flash_table done");
    bootResetFuse = 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      bootSizeFuses = s[1:0];
      repeat (2) @(negedge ref_clk);
      chk("resetAddr_q", bootStart[s], resetAddr_q);
      core.fetch(5'h01, got);
      chk("vecAddr_q", bootStart[s], got);
      core.fetch(5'h02, got);
      chk("vecAddr_q", 14'h0002, got);
    end
    bootSizeFuses = 2'h0;
    $display("test boot_fuse done");
    wr(ctl, 8'h02);
    rd(ctl, 8'h00);
    wr(ctl, 8'hEC);
    rd(ctl, 8'h00);
    wr(ctl, 8'h10);
    rd(ctl, 8'h10);
    chk("pullupGlobalOff_q", 14'h0001,
        {13'h0000, pullupGlobalOff_q});
    wr(ctl, 8'h00);
    $display("test plain_writes done");
    wr(ctl, 8'h01);
    // Counts the four open cycles and the first closed one
    for (int c = 1; c <= 5; c++)
    begin
      chk("unlock", 14'(c < 5), {13'h0000, vectorChangeUnlock_q});
      chk("irqBlock_q", 14'(c < 5), {13'h0000, irqBlock_q});
      @(negedge ref_clk);
    end
    wr(ctl, 8'h02);
    rd(ctl, 8'h00);
    $display("test unlock_timeout done");
    wr(ctl, 8'h01);
    wr(ctl, 8'h02);
    chk("select", 14'h0001, {13'h0000, vectorBaseSelect_q});
    chk("unlock", 14'h0000, {13'h0000, vectorChangeUnlock_q});
    blk(1'b1);
    core.retire();
    chk("irqBlock_q", 14'h0000, {13'h0000, irqBlock_q});
    rd(ctl, 8'h02);
    for (int n = 1; n <= 26; n++)
    begin
      core.fetch(n[4:0], got);
      chk("vecAddr_q", 14'h3C00 + 14'(2 * (n - 1)), got);
    end
    bootResetFuse = 1'b1;
    repeat (2) @(negedge ref_clk);
    core.fetch(5'h01, got);
    chk("vecAddr_q", 14'h0000, got);
    core.fetch(5'h02, got);
    chk("vecAddr_q", 14'h3C02, got);
    $display("test move_vectors done");
    appSectionLockBit = 1'b0;
    core.set_pc(14'h0100);
    blk(1'b1);
    core.set_pc(14'h3C10);
    blk(1'b0);
    appSectionLockBit = 1'b1;
    wr(ctl, 8'h01);
    wr(ctl, 8'h00);
    core.retire();
    rd(ctl, 8'h00);
    loaderSectionLockBit = 1'b0;
    blk(1'b1);
    core.set_pc(14'h0100);
    blk(1'b0);
    $display("test lock_block done");
    wr(ctl, 8'h01);
    rd(ctl, 8'h01);
    // Enable low must freeze the unlock countdown where it stands
    ce = 1'b0;
    repeat (6) @(negedge ref_clk);
    chk("unlock", 14'h0001, {13'h0000, vectorChangeUnlock_q});
    ce = 1'b1;
    @(negedge ref_clk);
    chk("unlock", 14'h0001, {13'h0000, vectorChangeUnlock_q});
    @(negedge ref_clk);
    chk("unlock", 14'h0000, {13'h0000, vectorChangeUnlock_q});
    chk("irqBlock_q", 14'h0000, {13'h0000, irqBlock_q});
    $display("test clock_enable done");
    wr(ctl, 8'h01);
    wr(ctl, 8'h12);
    chk("select", 14'h0001, {13'h0000, vectorBaseSelect_q});
    // Reset in the middle of the hold phase must clear every bit
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    chk("select", 14'h0000, {13'h0000, vectorBaseSelect_q});
    chk("irqBlock_q", 14'h0000, {13'h0000, irqBlock_q});
    rd(ctl, 8'h00);
    $display("test mid_reset done");
    close_out();
  end
endmodule
